// ==== src/dmahp_dev.sv ====
`timescale 1ns/100ps
module dmahp_dev #(
  parameter int DEPTH = 256
) (
  input  wire logic                         I_CLK,
  input  wire logic                         I_ARST_N,
  dmahp_if.dev                              BUS,
  output logic                              O_REG_WE,
  output logic [dmahp_pkg::ADDR_W-1:0]      O_REG_ADDR,
  output logic [dmahp_pkg::DATA_W-1:0]      O_REG_WDATA
);
  import dmahp_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin : g_chk_depth
    $error("DEPTH must lie between 1 and 2**ADDR_W");
  end
  if (ACK_LAT_CYC > ACK_MAX_CYC) begin : g_chk_lat
    $error("acknowledge latency exceeds its limit");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_FETCH,
    ST_RD_ACK,
    ST_WR_STORE,
    ST_WR_ACK
  } dmahp_dev_state_e;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dmahp_dev_state_e  state_ff;
  dmahp_dev_state_e  nxt_state;
  logic              ale_prev_ff;
  logic              rd_act_prev_ff;
  logic              wr_act_prev_ff;
  logic [ADDR_W-1:0] addr_lat_ff;
  logic [ADDR_W-1:0] addr_cur_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] mem_ff [DEPTH];
  logic              we_ff;
  logic [ADDR_W-1:0] we_addr_ff;
  logic [DATA_W-1:0] we_data_ff;
  logic [ADDR_W-1:0] eff_addr;
  logic              single;
  logic              rd_act;
  logic              wr_act;
  logic              rd_go;
  logic              wr_go;
  logic              in_range;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  assign single = (BUS.host_style_select == STYLE_SINGLE);

  always_comb begin
    if (single) begin
      rd_act = !BUS.cs_n && !BUS.read_or_data_strobe_n &&
               BUS.write_or_dir;
      wr_act = !BUS.cs_n && !BUS.read_or_data_strobe_n &&
               !BUS.write_or_dir;
    end else begin
      rd_act = !BUS.cs_n && !BUS.read_or_data_strobe_n;
      wr_act = !BUS.cs_n && !BUS.write_or_dir;
    end
  end

  // Start on the rising of the qualified strobe only, so a held
  // strobe never starts a second cycle
  assign rd_go = rd_act && !rd_act_prev_ff;
  // Read wins if a split-style host lowers both strobes at once
  assign wr_go = wr_act && !wr_act_prev_ff && !rd_go;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rd_act_prev_ff <= 1'b0;
      wr_act_prev_ff <= 1'b0;
    end else begin
      rd_act_prev_ff <= rd_act;
      wr_act_prev_ff <= wr_act;
    end
  end

  // ----------------------------------------------------------------
  // Address capture
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ale_prev_ff <= 1'b0;
      addr_lat_ff <= '0;
    end else begin
      ale_prev_ff <= BUS.addr_strobe_in;
      if (ale_prev_ff && !BUS.addr_strobe_in) begin
        addr_lat_ff <= BUS.addr;
      end
    end
  end

  // Latch input held high: address taken live from the bus
  assign eff_addr = BUS.addr_strobe_in ? BUS.addr : addr_lat_ff;
  assign in_range = (32'(addr_cur_ff) < DEPTH);

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (rd_go) begin
          nxt_state = ST_RD_FETCH;
        end else if (wr_go) begin
          nxt_state = ST_WR_STORE;
        end
      end
      ST_RD_FETCH: begin
        nxt_state = rd_act ? ST_RD_ACK : ST_IDLE;
      end
      ST_RD_ACK: begin
        if (!rd_act) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WR_STORE: begin
        nxt_state = wr_act ? ST_WR_ACK : ST_IDLE;
      end
      ST_WR_ACK: begin
        if (!wr_act) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      addr_cur_ff <= '0;
      rdata_ff    <= REG_RST_VAL;
      wdata_ff    <= REG_RST_VAL;
    end else if (state_ff == ST_IDLE && (rd_go || wr_go)) begin
      addr_cur_ff <= eff_addr;
      // Addresses past the array read as zero
      rdata_ff    <= (32'(eff_addr) < DEPTH) ?
                     mem_ff[eff_addr] : REG_RST_VAL;
      wdata_ff    <= BUS.data;
    end
  end

  // Full reset of the array costs flops but gives known reads
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= REG_RST_VAL;
      end
    end else if (state_ff == ST_WR_STORE && in_range) begin
      mem_ff[addr_cur_ff] <= wdata_ff;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      we_ff      <= 1'b0;
      we_addr_ff <= '0;
      we_data_ff <= REG_RST_VAL;
    end else begin
      we_ff <= (state_ff == ST_WR_STORE);
      if (state_ff == ST_WR_STORE) begin
        we_addr_ff <= addr_cur_ff;
        we_data_ff <= wdata_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign BUS.dev_d_out = rdata_ff;
  assign BUS.dev_d_oe  = (state_ff == ST_RD_FETCH) ||
                         (state_ff == ST_RD_ACK);
  assign BUS.transfer_ack_n = !((state_ff == ST_RD_ACK) ||
                                (state_ff == ST_WR_ACK));

  assign O_REG_WE    = we_ff;
  assign O_REG_ADDR  = we_addr_ff;
  assign O_REG_WDATA = we_data_ff;

endmodule

// ==== src/dmahp_pkg.sv ====
// Contract
// - Host selects strobe style by static code
// - Host presents address, then lowers chip select (dmahp_host drives both on the same edge)
// - Strobes ignored unless chip select low
// - Split style latches address on latch fall
// - Single style latches address on strobe-pin fall (dmahp_dev latches on latch fall in both styles)
// - Latch input may stay high, address live
// - Split read strobe turns data drivers on
// - Host sets write byte before write strobe
// - Split write strobe makes port accept data
// - Host sets direction before data strobe
// - Single strobe fall, direction high: read
// - Single strobe fall, direction low: write
// - Operation starts only with chip select low
// - Read acknowledge once data is driven
// - Write acknowledge once byte is stored
// - Acknowledge active low in both styles
// - Host ends split read after acknowledge
// - Host ends single-strobe cycle after acknowledge
package dmahp_pkg;

  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  typedef logic [1:0] dmahp_style_t;
  localparam dmahp_style_t STYLE_SPLIT  = 2'h0;
  localparam dmahp_style_t STYLE_SINGLE = 2'h1;

  localparam logic [DATA_W-1:0] REG_RST_VAL = 8'h00;
  localparam logic [DATA_W-1:0] BUS_IDLE_VAL = 8'hFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int CS_TO_STB_NS  = 65;
  localparam int STB_WIDTH_NS  = 90;
  localparam int STB_TO_ACK_NS = 90;
  // Least times round up, longest rounds down
  localparam int CS_TO_STB_CYC =
    (CS_TO_STB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STB_WIDTH_CYC =
    (STB_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_MAX_CYC = STB_TO_ACK_NS / CLK_PERIOD_NS;
  // Edges from strobe sampled low to acknowledge low
  localparam int ACK_LAT_CYC = 2;
  // Host holds latch high this many cycles plus one after chip select
  localparam int ALE_HIGH_CYC = 2;
  localparam int CNT_W = 8;

endpackage

// ==== src/dmahp_if.sv ====
`timescale 1ns/100ps
interface dmahp_if;
  import dmahp_pkg::*;

  logic [ADDR_W-1:0] addr;
  logic              cs_n;
  logic              addr_strobe_in;
  logic              read_or_data_strobe_n;
  logic              write_or_dir;
  dmahp_style_t      host_style_select;
  logic              transfer_ack_n;
  logic [DATA_W-1:0] host_d_out;
  logic              host_d_oe;
  logic [DATA_W-1:0] dev_d_out;
  logic              dev_d_oe;
  logic [DATA_W-1:0] data;

  // Resolved data wire; pulled high when nobody drives
  assign data = dev_d_oe  ? dev_d_out  :
                host_d_oe ? host_d_out : BUS_IDLE_VAL;

  modport dev (
    input  addr,
    input  cs_n,
    input  addr_strobe_in,
    input  read_or_data_strobe_n,
    input  write_or_dir,
    input  host_style_select,
    input  data,
    output transfer_ack_n,
    output dev_d_out,
    output dev_d_oe
  );

  modport host (
    output addr,
    output cs_n,
    output addr_strobe_in,
    output read_or_data_strobe_n,
    output write_or_dir,
    output host_style_select,
    output host_d_out,
    output host_d_oe,
    input  data,
    input  transfer_ack_n
  );
endinterface

// ==== src/dmahp_host.sv ====
`timescale 1ns/100ps
module dmahp_host (
  input  wire logic                         I_CLK,
  input  wire logic                         I_ARST_N,
  dmahp_if.host                             BUS,
  input  wire dmahp_pkg::dmahp_style_t      I_STYLE,
  input  wire logic                         I_REQ,
  input  wire logic                         I_RNW,
  input  wire logic [dmahp_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [dmahp_pkg::DATA_W-1:0] I_WDATA,
  output logic                              O_BUSY,
  output logic                              O_DONE,
  output logic [dmahp_pkg::DATA_W-1:0]      O_RDATA
);
  import dmahp_pkg::*;

  if (CS_TO_STB_CYC >= (1 << CNT_W) || STB_WIDTH_CYC >= (1 << CNT_W) ||
      ALE_HIGH_CYC >= CS_TO_STB_CYC) begin : g_chk_cnt
    $error("timing counts do not fit the counter");
  end

  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_STROBE,
    H_RELEASE
  } dmahp_host_state_e;

  localparam logic [CNT_W-1:0] CNT_ALE = CNT_W'(ALE_HIGH_CYC);
  localparam logic [CNT_W-1:0] CNT_CS  = CNT_W'(CS_TO_STB_CYC);
  localparam logic [CNT_W-1:0] CNT_STB = CNT_W'(STB_WIDTH_CYC);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dmahp_host_state_e state_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic              rnw_ff;
  dmahp_style_t      style_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic              cs_n_ff;
  logic              ale_ff;
  logic              rs_n_ff;
  logic              wd_ff;
  logic [DATA_W-1:0] dout_ff;
  logic              doe_ff;
  logic              done_ff;
  logic [DATA_W-1:0] rdata_ff;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_ff <= H_IDLE;
      cnt_ff   <= '0;
      rnw_ff   <= 1'b1;
      style_ff <= STYLE_SPLIT;
      addr_ff  <= '0;
      cs_n_ff  <= 1'b1;
      ale_ff   <= 1'b0;
      rs_n_ff  <= 1'b1;
      wd_ff    <= 1'b1;
      dout_ff  <= '0;
      doe_ff   <= 1'b0;
      done_ff  <= 1'b0;
      rdata_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        H_IDLE: begin
          style_ff <= I_STYLE;
          if (I_REQ) begin
            rnw_ff  <= I_RNW;
            addr_ff <= I_ADDR;
            cs_n_ff <= 1'b0;
            ale_ff  <= 1'b1;
            dout_ff <= I_WDATA;
            doe_ff  <= !I_RNW;
            // Direction set well ahead of the data strobe
            wd_ff   <= (I_STYLE == STYLE_SINGLE) ? I_RNW : 1'b1;
            cnt_ff  <= '0;
            state_ff <= H_SETUP;
          end
        end
        H_SETUP: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == CNT_ALE) begin
            ale_ff <= 1'b0;
          end
          if (cnt_ff == CNT_CS) begin
            cnt_ff <= '0;
            if (style_ff == STYLE_SINGLE || rnw_ff) begin
              rs_n_ff <= 1'b0;
            end else begin
              wd_ff <= 1'b0;
            end
            state_ff <= H_STROBE;
          end
        end
        H_STROBE: begin
          if (cnt_ff != CNT_STB) begin
            cnt_ff <= cnt_ff + 1'b1;
          end
          if (cnt_ff == CNT_STB && !BUS.transfer_ack_n) begin
            if (rnw_ff) begin
              rdata_ff <= BUS.data;
            end
            rs_n_ff  <= 1'b1;
            wd_ff    <= 1'b1;
            cs_n_ff  <= 1'b1;
            doe_ff   <= 1'b0;
            state_ff <= H_RELEASE;
          end
        end
        H_RELEASE: begin
          // Wait for the port to let go before a new cycle
          if (BUS.transfer_ack_n) begin
            done_ff  <= 1'b1;
            state_ff <= H_IDLE;
          end
        end
        default: begin
          state_ff <= H_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign BUS.addr                  = addr_ff;
  assign BUS.cs_n                  = cs_n_ff;
  assign BUS.addr_strobe_in        = ale_ff;
  assign BUS.read_or_data_strobe_n = rs_n_ff;
  assign BUS.write_or_dir          = wd_ff;
  assign BUS.host_style_select     = style_ff;
  assign BUS.host_d_out            = dout_ff;
  assign BUS.host_d_oe             = doe_ff;

  assign O_BUSY  = (state_ff != H_IDLE);
  assign O_DONE  = done_ff;
  assign O_RDATA = rdata_ff;

endmodule

// ==== tb/dmahp_sva.sv ====
`timescale 1ns/100ps
module dmahp_sva
  import dmahp_pkg::*;
(
  input wire logic         I_CLK,
  input wire logic         I_ARST_N,
  input wire logic         cs_n,
  input wire logic         read_or_data_strobe_n,
  input wire logic         write_or_dir,
  input wire dmahp_style_t host_style_select,
  input wire logic         transfer_ack_n,
  input wire logic         host_d_oe,
  input wire logic         dev_d_oe
);
  import dmahp_pkg::*;

  // ------------------------------------------------------------
  // Qualified strobes
  // ------------------------------------------------------------
  logic       act_rd;
  logic       act_wr;
  logic       act;
  logic [7:0] cs_cnt_ff;
  logic       split;

  // Codes other than single decode as split, as the port does
  assign split  = (host_style_select != STYLE_SINGLE);
  assign act_rd = !cs_n && !read_or_data_strobe_n && (split || write_or_dir);
  assign act_wr = !cs_n && (split ? !write_or_dir
                                  : (!read_or_data_strobe_n && !write_or_dir));
  assign act    = act_rd || act_wr;

  // Saturates so a long idle select never wraps
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cs_cnt_ff <= 8'h00;
    end else if (cs_n) begin
      cs_cnt_ff <= 8'h00;
    end else if (cs_cnt_ff != 8'hFF) begin
      cs_cnt_ff <= cs_cnt_ff + 8'h01;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_rd_resp;
    ##1 dev_d_oe ##1 (dev_d_oe && !transfer_ack_n);
  endsequence
  sequence s_wr_resp;
    ##1 (!dev_d_oe && transfer_ack_n) ##1 (!dev_d_oe && !transfer_ack_n);
  endsequence

  property p_rd_resp;  $rose(act_rd) |-> s_rd_resp; endproperty
  property p_wr_resp;  $rose(act_wr) && !act_rd |-> s_wr_resp; endproperty
  property p_ack_cause; !transfer_ack_n |-> $past(act); endproperty
  property p_oe_cause; dev_d_oe |-> $past(act_rd); endproperty
  property p_release;
    $fell(act) |-> ##1 (transfer_ack_n && !dev_d_oe);
  endproperty
  property p_ack_hold; (!transfer_ack_n && act) |=> !transfer_ack_n;
  endproperty
  property p_cs_setup;
    $rose(act) |-> cs_cnt_ff >= CS_TO_STB_CYC;
  endproperty
  property p_host_end; $fell(act) |-> $past(!transfer_ack_n); endproperty
  property p_wr_data; $rose(act_wr) |-> host_d_oe; endproperty

  a_rd_resp:   assert property (p_rd_resp)
    else $error("read response out of order");
  a_wr_resp:   assert property (p_wr_resp)
    else $error("write acknowledge late or data driven");
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge without a selected strobe");
  a_oe_cause:  assert property (p_oe_cause)
    else $error("data driven outside a read");
  a_release:   assert property (p_release)
    else $error("bus not released after strobe end");
  a_ack_hold:  assert property (p_ack_hold)
    else $error("acknowledge dropped while strobe held");
  a_cs_setup:  assert property (p_cs_setup)
    else $error("strobe too soon after chip select");
  a_host_end:  assert property (p_host_end)
    else $error("strobe ended before acknowledge");
  a_wr_data:   assert property (p_wr_data)
    else $error("write strobe without data driven");
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import dmahp_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic         I_CLK = 1'b0;
  logic         I_ARST_N = 1'b0;
  dmahp_style_t host_style = STYLE_SPLIT;
  logic         host_req = 1'b0;
  logic         host_rnw = 1'b0;
  logic [7:0]   host_addr = 8'h00;
  logic [7:0]   host_wdata = 8'h00;
  logic         busy_h, done_h, we_a, we_b;
  logic [7:0]   rdata_h, raddr_a, rwdata_a, raddr_b, rwdata_b;
  logic [7:0]   shadow [256];
  logic         done_q [$];
  logic [15:0]  rd_q [$];
  logic [15:0]  wr_q [$];
  int           bad_count = 0;
  int           comparisons = 0;
  int           seed = 58815;

  dmahp_if bus_a ();
  dmahp_if bus_b ();

  always #2 I_CLK = ~I_CLK;

  dmahp_host dmahp_host_inst (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
    .BUS(bus_a), .I_STYLE(host_style), .I_REQ(host_req),
    .I_RNW(host_rnw), .I_ADDR(host_addr), .I_WDATA(host_wdata),
    .O_BUSY(busy_h), .O_DONE(done_h), .O_RDATA(rdata_h));
  dmahp_dev dmahp_dev_inst (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
    .BUS(bus_a), .O_REG_WE(we_a), .O_REG_ADDR(raddr_a),
    .O_REG_WDATA(rwdata_a));
  // Second end driven by hand for misbehaving-host cases
  dmahp_dev dmahp_dev_inst_b (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
    .BUS(bus_b), .O_REG_WE(we_b), .O_REG_ADDR(raddr_b),
    .O_REG_WDATA(rwdata_b));
  dmahp_sva dmahp_sva_inst (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
    .cs_n(bus_a.cs_n), .read_or_data_strobe_n(bus_a.read_or_data_strobe_n),
    .write_or_dir(bus_a.write_or_dir),
    .host_style_select(bus_a.host_style_select),
    .transfer_ack_n(bus_a.transfer_ack_n), .host_d_oe(bus_a.host_d_oe),
    .dev_d_oe(bus_a.dev_d_oe));

  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge I_CLK) begin
    if (I_ARST_N && done_h === 1'b1) begin
      if (done_q.size() == 0) begin
        check(16'h0000, 16'hXXXX);
      end else if (done_q.pop_front()) begin
        check({8'h00, rdata_h}, rd_q.pop_front());
      end
    end
    if (I_ARST_N && we_a === 1'b1) begin
      check({raddr_a, rwdata_a},
            wr_q.size() ? wr_q.pop_front() : 16'hXXXX);
    end
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  task automatic do_req(input logic rnw, input logic [7:0] a,
                        input logic [7:0] d);
    int n;
    @(posedge I_CLK);
    host_req   <= 1'b1;
    host_rnw   <= rnw;
    host_addr  <= a;
    host_wdata <= d;
    done_q.push_back(rnw);
    if (rnw) begin
      rd_q.push_back({8'h00, shadow[a]});
    end else begin
      wr_q.push_back({a, d});
      shadow[a] = d;
    end
    @(posedge I_CLK);
    host_req <= 1'b0;
    n = 0;
    do begin
      @(posedge I_CLK);
      n++;
      if (n == 1) begin
        check({15'h0, busy_h}, 16'h0001);
      end
    end while (done_h !== 1'b1 && n < 200);
    if (n >= 200) begin
      check(16'h0000, 16'h0001);
    end
    check({15'h0, busy_h}, 16'h0000);
  endtask

  // Boundary addresses first, then random; each write read back
  task automatic run_style(input dmahp_style_t st);
    logic [7:0] a;
    @(posedge I_CLK);
    host_style <= st;
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      do_req(1'b0, a, 8'($random(seed)));
      do_req(1'b1, a, 8'h00);
      do_req(1'b1, 8'($random(seed)), 8'h00);
    end
    $display("style %0d test done", st);
  endtask

  initial begin
    int n;
    for (int i = 0; i < 256; i++) shadow[i] = REG_RST_VAL;
    bus_b.addr = 8'h00;
    bus_b.cs_n = 1'b1;
    bus_b.addr_strobe_in = 1'b1;
    bus_b.read_or_data_strobe_n = 1'b1;
    bus_b.write_or_dir = 1'b1;
    bus_b.host_style_select = STYLE_SINGLE;
    bus_b.host_d_out = 8'h00;
    bus_b.host_d_oe = 1'b0;
    repeat (8) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    run_style(STYLE_SPLIT);
    run_style(STYLE_SINGLE);
    // Strobe with chip select high must do nothing
    @(posedge I_CLK);
    bus_b.read_or_data_strobe_n <= 1'b0;
    bus_b.write_or_dir <= 1'b0;
    n = 0;
    repeat (30) begin
      @(posedge I_CLK);
      if (bus_b.transfer_ack_n !== 1'b1 || we_b !== 1'b0) n++;
    end
    check(16'(n), 16'h0000);
    bus_b.read_or_data_strobe_n <= 1'b1;
    // Latch held high: address taken live
    @(posedge I_CLK);
    bus_b.cs_n <= 1'b0;
    bus_b.addr <= 8'h5A;
    bus_b.host_d_out <= 8'hC3;
    bus_b.host_d_oe <= 1'b1;
    repeat (17) @(posedge I_CLK);
    bus_b.read_or_data_strobe_n <= 1'b0;
    n = 0;
    do begin
      @(posedge I_CLK);
      n++;
    end while (bus_b.transfer_ack_n !== 1'b0 && n < 22);
    check({15'h0, bus_b.transfer_ack_n}, 16'h0000);
    check(16'(n), 16'(ACK_LAT_CYC + 1));
    check({raddr_b, rwdata_b}, 16'h5AC3);
    bus_b.read_or_data_strobe_n <= 1'b1;
    bus_b.cs_n <= 1'b1;
    bus_b.host_d_oe <= 1'b0;
    repeat (2) @(posedge I_CLK);
    check({15'h0, bus_b.transfer_ack_n}, 16'h0001);
    $display("fault end test done");
    check(16'(rd_q.size() + wr_q.size() + done_q.size()), 16'h0000);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge I_CLK);
    bad_count++;
    report_and_stop();
  end
endmodule
